// *** core/slvq_pkg.sv ***
package slvq_pkg;
    localparam int COEF_W = 16;
    localparam int FRAC = 4;
    localparam int N_COEF = 64;
    localparam int N_BAND = 8;
    localparam int DIM = 8;
    localparam int FIFO_DEPTH = 32;
    localparam int N_ITER = 10;
    localparam int LOG_Q = 8;
    localparam int DIV10_SH = 11;
    localparam logic [15:0] FAC_INIT = 16'h8000;
    localparam logic [15:0] OFFSET_INIT = 16'h0000;
    localparam logic [15:0] ONE_Q = 16'h0010;
    localparam logic [35:0] E_MIN = 36'h000000200;
    localparam logic [7:0] LIMIT_MUL = 8'hF3;
    localparam logic [7:0] DIV10_MUL = 8'hCD;
    localparam logic [3:0] IDX_PER_CB = 4'h4;
    localparam logic [3:0] BITS_PER_CB = 4'h5;
    localparam logic [5:0] EXT_BITS = 6'h08;
    localparam logic [1:0] MAX_ORDER = 2'h2;
    localparam logic [3:0] CB_EXT_FIRST = 4'h5;
    localparam logic [3:0] CB_ORD2_FIRST = 4'h7;
    localparam logic [3:0] CB_BASE_ODD = 4'h3;
    localparam logic [3:0] CB_BASE_EVEN = 4'h4;
    localparam logic [3:0] CB_MAX = 4'h8;
    // largest sphere index codebooks 2..7 accept; 8 takes anything larger
    localparam logic [31:0] SPH_LIM [9] = '{32'h0, 32'h0, 32'h2, 32'h3, 32'h4,
                                            32'hC, 32'h10, 32'h30, 32'h40};
    localparam logic [5:0] CNT_INIT = 6'h00;
    localparam logic [2:0] BAND_INIT = 3'h0;
    localparam logic [2:0] BAND_LAST = 3'h7;
    localparam logic [5:0] CNT_LAST = 6'h3F;
    localparam logic [3:0] ITER_LAST = 4'h9;

    typedef logic [DIM-1:0][15:0] slvq_vec_t;

    typedef enum logic [2:0] {
        SLVQ_COLLECT = 3'b000,
        SLVQ_ENERGY = 3'b001,
        SLVQ_SEARCH = 3'b010,
        SLVQ_GAIN = 3'b011,
        SLVQ_QUANT = 3'b100
    } slvq_state_e;

    typedef struct packed {
        logic [2:0] band;
        slvq_vec_t point;
        slvq_vec_t base_point;
        slvq_vec_t qspec;
        logic [3:0] cb_num;
        logic [3:0] base_cb;
        logic [1:0] ext_order;
        logic [7:0] unary;
        logic [3:0] unary_len;
        logic [5:0] index_bits;
        logic [6:0] total_bits;
        logic trunc;
        logic short;
    } slvq_band_s;

    function automatic logic [15:0] log2_half(input logic [35:0] x);
        int p;
        logic [35:0] sh;
        p = 0;
        for (int i = 0; i < 36; i++)
        begin
            if (x[i])
            begin
                p = i;
            end
        end
        sh = x << (35 - p);
        // linear mantissa keeps this a shifter, not a table
        log2_half = {8'(p - LOG_Q - 1), sh[34:27]};
    endfunction

    function automatic slvq_vec_t nn_cand(input slvq_vec_t x, input logic odd);
        slvq_vec_t y;
        logic [15:0] xs, d, dabs, best, sum;
        logic [17:0] r;
        logic neg;
        int imax;
        y = '0;
        sum = '0;
        best = '0;
        neg = 1'b0;
        imax = 0;
        for (int i = 0; i < DIM; i++)
        begin
            xs = odd ? 16'(x[i] - ONE_Q) : x[i];
            r = 18'($signed({{2{xs[15]}}, xs}) + $signed(18'(ONE_Q)) >>> (FRAC + 1));
            y[i] = 16'(r << 1);
            d = 16'(xs - 16'(y[i] << FRAC));
            dabs = d[15] ? 16'(-d) : d;
            if (dabs > best)
            begin
                best = dabs;
                imax = i;
                neg = d[15];
            end
            sum = 16'(sum + y[i]);
        end
        if (sum[1:0] != 2'b00)
        begin
            y[imax] = neg ? 16'(y[imax] - 16'h0002) : 16'(y[imax] + 16'h0002);
        end
        for (int i = 0; i < DIM; i++)
        begin
            y[i] = odd ? 16'(y[i] + 16'h0001) : y[i];
        end
        nn_cand = y;
    endfunction

    function automatic logic [35:0] sq_err(input slvq_vec_t x, input slvq_vec_t y);
        logic [15:0] d;
        logic signed [31:0] sq;
        sq_err = '0;
        for (int i = 0; i < DIM; i++)
        begin
            d = 16'(x[i] - 16'(y[i] << FRAC));
            sq = $signed(d) * $signed(d);
            sq_err = 36'(sq_err + {4'h0, sq});
        end
    endfunction

    function automatic logic is_lattice(input slvq_vec_t y);
        logic [15:0] s;
        logic par_ok;
        s = '0;
        par_ok = 1'b1;
        for (int i = 0; i < DIM; i++)
        begin
            s = 16'(s + y[i]);
            par_ok = par_ok && (y[i][0] == y[0][0]);
        end
        is_lattice = par_ok && (s[1:0] == 2'b00);
    endfunction

    function automatic logic [3:0] base_of(input logic [3:0] n);
        if (n < CB_EXT_FIRST)
        begin
            base_of = n;
        end
        else
        begin
            base_of = n[0] ? CB_BASE_ODD : CB_BASE_EVEN;
        end
    endfunction

    function automatic logic [1:0] order_of(input logic [3:0] n);
        if (n < CB_EXT_FIRST)
        begin
            order_of = 2'h0;
        end
        else
        begin
            order_of = (n < CB_ORD2_FIRST) ? 2'h1 : MAX_ORDER;
        end
    endfunction
endpackage

// *** core/slvq_fifo.sv ***
`timescale 1ns/1ns
`default_nettype none
module slvq_fifo
    import slvq_pkg::*;
#(
    parameter int WIDTH = 16,
    parameter int DEPTH = 32
)
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_valid,
    input wire logic [WIDTH-1:0] i_data,
    output logic o_ready,
    output logic o_valid,
    output logic [WIDTH-1:0] o_data,
    input wire logic i_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr, rd_ptr, next_wr, next_rd;
    logic [AW:0] count, next_count;
    logic room, next_room, push, pop;

    assign push = i_valid && room;
    assign pop = o_valid && i_ready;
    assign o_valid = (count != '0);
    assign o_data = mem[rd_ptr];
    // room is its own flop so ready has no gate behind it
    assign o_ready = room;

    always_comb
    begin
        next_wr = push ? wr_ptr + 1'b1 : wr_ptr;
        next_rd = pop ? rd_ptr + 1'b1 : rd_ptr;
        case ({push, pop})
            2'b10: next_count = count + 1'b1;
            2'b01: next_count = count - 1'b1;
            default: next_count = count;
        endcase
        next_room = (next_count != (AW+1)'(DEPTH));
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            room <= 1'b1;
        end
        else
        begin
            wr_ptr <= next_wr;
            rd_ptr <= next_rd;
            count <= next_count;
            room <= next_room;
        end
        if (push)
        begin
            mem[wr_ptr] <= i_data;
        end
    end
endmodule
`default_nettype wire

// *** core/slvq_quantizer.sv ***
`timescale 1ns/1ns
`default_nettype none
// Function
// - 64 coefficients split into eight 8-wide bands
// - lattice points: equal parity, sum multiple of 4
// - base codebooks 0,2,3,4 need 4n index bits
// - extended point is scaled base plus extension
// - order at most 2, only on base 3/4
// - numbers 5..8 map to base 3/4, order 1/2
// - codebook number sent as ones then zero
// - number zero: origin point, one bit only
// - numbers 2..4: unary plus 4n index bits
// - extended: unary, base index, 8 bits per order
// - last band drops terminating zero when exactly one bit short
// - band energy sum of squares, floor 2
// - band estimate five times log2 half energy
// - search starts step 128, limit 0.95(budget-bands)
// - ten halving iterations adjust the offset
// - gain two to offset tenth divides spectrum
// - scale down, lattice quantize, scale back up
// - nearest point by rounding, no table search
module slvq_quantizer
    import slvq_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_coef_valid,
    input wire logic [COEF_W-1:0] i_coef,
    output logic o_coef_ready,
    input wire logic [15:0] i_bit_budget,
    output logic o_band_valid,
    output slvq_band_s o_band,
    output logic o_frame_done,
    output logic [15:0] o_offset
);
    logic f_valid, f_ready;
    logic [COEF_W-1:0] f_data;
    logic [COEF_W-1:0] mem [N_COEF];
    logic [15:0] rate [N_BAND];

    slvq_state_e state, next_state;
    logic [5:0] cnt, next_cnt;
    logic [2:0] band, next_band;
    logic [3:0] iter, next_iter;
    logic [15:0] fac, next_fac, offset, next_offset, remain, next_remain;
    logic [23:0] limit, next_limit;
    logic [4:0] gint, next_gint;
    logic [7:0] gfrac, next_gfrac;
    logic band_valid, next_band_valid, done, next_done;
    slvq_band_s band_out, next_band_out;

    logic [35:0] energy;
    logic [15:0] next_rate, off_try;
    logic [19:0] nbits;
    logic [23:0] e_q8;
    logic [8:0] mult_dn, mult_up;
    slvq_vec_t xn, y1, y2, yq, zb, qs;
    logic [35:0] e1, e2;
    logic [31:0] ksph;
    logic [3:0] ncb;
    logic [6:0] cost;

    slvq_fifo #(.WIDTH(COEF_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_valid(i_coef_valid),
        .i_data(i_coef),
        .o_ready(o_coef_ready),
        .o_valid(f_valid),
        .o_data(f_data),
        .i_ready(f_ready)
    );

    // FIFO reads stall while a frame is being worked on; input keeps filling the FIFO
    assign f_ready = (state == SLVQ_COLLECT);

    function automatic logic [6:0] cost_of(input logic [3:0] n);
        cost_of = (n == 4'h0) ? 7'h01 : 7'(n * BITS_PER_CB);
    endfunction

    // band energy and bit estimate
    always_comb
    begin
        logic signed [31:0] sq;
        sq = '0;
        energy = '0;
        for (int i = 0; i < DIM; i++)
        begin
            sq = $signed(mem[{band, 3'(i)}]) * $signed(mem[{band, 3'(i)}]);
            energy = 36'(energy + {4'h0, sq});
        end
        if (energy < E_MIN)
        begin
            energy = E_MIN;
        end
        next_rate = 16'(log2_half(energy) * 16'h0005);
    end

    // one search iteration across all bands
    always_comb
    begin
        off_try = 16'(offset + fac);
        nbits = '0;
        for (int j = 0; j < N_BAND; j++)
        begin
            if (rate[j] > off_try)
            begin
                nbits = 20'(nbits + (rate[j] - off_try));
            end
        end
    end

    // normalize, nearest point, codebook selection
    always_comb
    begin
        logic signed [25:0] prod;
        logic signed [25:0] prod2;
        e_q8 = 24'((offset * DIV10_MUL) >> DIV10_SH);
        mult_dn = 9'(9'h100 - {1'b0, gfrac[7:1]});
        mult_up = 9'(9'h100 + {1'b0, gfrac});
        prod = '0;
        prod2 = '0;
        for (int i = 0; i < DIM; i++)
        begin
            prod = $signed(mem[{band, 3'(i)}]) * $signed({1'b0, mult_dn});
            xn[i] = 16'(prod >>> (LOG_Q + gint));
        end
        y1 = nn_cand(xn, 1'b0);
        y2 = nn_cand(xn, 1'b1);
        e1 = sq_err(xn, y1);
        e2 = sq_err(xn, y2);
        yq = (e1 <= e2) ? y1 : y2;
        ksph = '0;
        for (int i = 0; i < DIM; i++)
        begin
            ksph = 32'(ksph + 32'($signed(yq[i]) * $signed(yq[i])));
        end
        ksph = ksph >> 3;
        ncb = CB_MAX;
        for (int m = 7; m >= 2; m--)
        begin
            if (ksph <= SPH_LIM[m])
            begin
                ncb = 4'(m);
            end
        end
        if (ksph == 32'h0)
        begin
            ncb = 4'h0;
        end
        for (int i = 0; i < DIM; i++)
        begin
            zb[i] = 16'($signed(yq[i]) >>> order_of(ncb));
            prod2 = $signed(16'(yq[i] << FRAC)) * $signed({1'b0, mult_up});
            qs[i] = 16'((prod2 >>> LOG_Q) <<< gint);
        end
        cost = cost_of(ncb);
    end

    always_comb
    begin
        next_state = state;
        next_cnt = cnt;
        next_band = band;
        next_iter = iter;
        next_fac = fac;
        next_offset = offset;
        next_remain = remain;
        next_limit = limit;
        next_gint = gint;
        next_gfrac = gfrac;
        next_band_valid = 1'b0;
        // done trails the last band by one cycle
        next_done = band_valid && (band_out.band == BAND_LAST);
        next_band_out = band_out;
        unique case (state)
            SLVQ_COLLECT:
            begin
                if (f_valid)
                begin
                    next_cnt = 6'(cnt + 1'b1);
                    if (cnt == CNT_LAST)
                    begin
                        next_state = SLVQ_ENERGY;
                        next_band = BAND_INIT;
                        next_remain = i_bit_budget;
                        next_limit = (i_bit_budget > 16'(N_BAND)) ?
                            24'((i_bit_budget - 16'(N_BAND)) * LIMIT_MUL) : 24'h0;
                    end
                end
            end
            SLVQ_ENERGY:
            begin
                next_band = 3'(band + 1'b1);
                if (band == BAND_LAST)
                begin
                    next_state = SLVQ_SEARCH;
                    next_iter = 4'h0;
                    next_fac = FAC_INIT;
                    next_offset = OFFSET_INIT;
                end
            end
            SLVQ_SEARCH:
            begin
                next_offset = ({4'h0, nbits} <= limit) ? offset : off_try;
                next_fac = fac >> 1;
                next_iter = 4'(iter + 1'b1);
                if (iter == ITER_LAST)
                begin
                    next_state = SLVQ_GAIN;
                end
            end
            SLVQ_GAIN:
            begin
                next_gint = 5'(e_q8 >> LOG_Q);
                next_gfrac = e_q8[7:0];
                next_band = BAND_INIT;
                next_state = SLVQ_QUANT;
            end
            SLVQ_QUANT:
            begin
                next_band_valid = 1'b1;
                next_band_out.band = band;
                next_band_out.point = yq;
                next_band_out.base_point = zb;
                next_band_out.qspec = qs;
                next_band_out.cb_num = ncb;
                next_band_out.base_cb = base_of(ncb);
                next_band_out.ext_order = order_of(ncb);
                next_band_out.unary = (ncb == 4'h0) ? 8'h00 : 8'((9'h001 << ncb) - 9'h002);
                next_band_out.unary_len = (ncb == 4'h0) ? 4'h1 : ncb;
                next_band_out.index_bits = 6'(base_of(ncb) * IDX_PER_CB) +
                    6'(order_of(ncb) * EXT_BITS);
                next_band_out.total_bits = cost;
                next_band_out.trunc = 1'b0;
                // only the final band may run one bit short
                if (band == BAND_LAST && ncb != 4'h0 && remain == 16'(cost - 1'b1))
                begin
                    next_band_out.trunc = 1'b1;
                    next_band_out.unary = 8'(((9'h001 << ncb) - 9'h002) >> 1);
                    next_band_out.unary_len = 4'(ncb - 1'b1);
                    next_band_out.total_bits = 7'(cost - 1'b1);
                end
                next_band_out.short = (remain < 16'(next_band_out.total_bits));
                next_remain = next_band_out.short ? 16'h0 :
                    16'(remain - next_band_out.total_bits);
                next_band = 3'(band + 1'b1);
                if (band == BAND_LAST)
                begin
                    next_state = SLVQ_COLLECT;
                    next_cnt = CNT_INIT;
                end
            end
            default:
            begin
                next_state = SLVQ_COLLECT;
            end
        endcase
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            state <= SLVQ_COLLECT;
            cnt <= CNT_INIT;
            band <= BAND_INIT;
            iter <= 4'h0;
            fac <= FAC_INIT;
            offset <= OFFSET_INIT;
            remain <= 16'h0;
            limit <= 24'h0;
            gint <= 5'h0;
            gfrac <= 8'h0;
            band_valid <= 1'b0;
            done <= 1'b0;
            band_out <= '0;
        end
        else
        begin
            state <= next_state;
            cnt <= next_cnt;
            band <= next_band;
            iter <= next_iter;
            fac <= next_fac;
            offset <= next_offset;
            remain <= next_remain;
            limit <= next_limit;
            gint <= next_gint;
            gfrac <= next_gfrac;
            band_valid <= next_band_valid;
            done <= next_done;
            band_out <= next_band_out;
        end
        if (state == SLVQ_COLLECT && f_valid)
        begin
            mem[cnt] <= f_data;
        end
        if (state == SLVQ_ENERGY)
        begin
            rate[band] <= next_rate;
        end
    end

    assign o_band_valid = band_valid;
    assign o_band = band_out;
    assign o_frame_done = done;
    assign o_offset = offset;

    AST_BAND_ORDER: assert property (@(posedge i_clk) disable iff (i_rst)
        o_band_valid && o_band.band != BAND_LAST |=> o_band_valid &&
        o_band.band == 3'($past(o_band.band) + 1'b1))
        else $error("bands not emitted in order");
    AST_LATTICE: assert property (@(posedge i_clk) disable iff (i_rst)
        o_band_valid |-> is_lattice(o_band.point))
        else $error("emitted point is not a lattice point");
    AST_BASE_BITS: assert property (@(posedge i_clk) disable iff (i_rst)
        o_band_valid && o_band.cb_num < CB_EXT_FIRST |->
        o_band.index_bits == 6'(o_band.cb_num * IDX_PER_CB))
        else $error("base codebook index width wrong");
    AST_EXT_BASE: assert property (@(posedge i_clk) disable iff (i_rst)
        o_band_valid && o_band.ext_order != 2'h0 |-> o_band.ext_order <= MAX_ORDER &&
        (o_band.base_cb == CB_BASE_ODD || o_band.base_cb == CB_BASE_EVEN))
        else $error("extension on wrong base codebook");
    AST_MAP: assert property (@(posedge i_clk) disable iff (i_rst)
        o_band_valid && o_band.cb_num == CB_ORD2_FIRST |->
        o_band.base_cb == CB_BASE_ODD && o_band.ext_order == MAX_ORDER)
        else $error("codebook seven mapped wrongly");
    AST_UNARY: assert property (@(posedge i_clk) disable iff (i_rst)
        o_band_valid && !o_band.trunc && o_band.cb_num != 4'h0 |->
        o_band.unary_len == o_band.cb_num && o_band.unary[0] == 1'b0)
        else $error("unary code malformed");
    AST_ZERO_CB: assert property (@(posedge i_clk) disable iff (i_rst)
        o_band_valid && o_band.cb_num == 4'h0 |->
        o_band.total_bits == 7'h01 && o_band.point == '0)
        else $error("codebook zero cost or point wrong");
    AST_EXT_BITS: assert property (@(posedge i_clk) disable iff (i_rst)
        o_band_valid && o_band.cb_num >= CB_EXT_FIRST && !o_band.trunc |->
        o_band.total_bits == 7'(o_band.cb_num * BITS_PER_CB) &&
        o_band.index_bits == 6'(o_band.base_cb * IDX_PER_CB) + 6'(o_band.ext_order * EXT_BITS))
        else $error("extended codebook bit count wrong");
    AST_TRUNC: assert property (@(posedge i_clk) disable iff (i_rst)
        o_band_valid && o_band.trunc |-> o_band.band == BAND_LAST &&
        o_band.total_bits == 7'(o_band.cb_num * BITS_PER_CB - 1'b1))
        else $error("terminating zero dropped wrongly");
    AST_SEARCH_START: assert property (@(posedge i_clk) disable iff (i_rst)
        $rose(state == SLVQ_SEARCH) |-> fac == FAC_INIT && offset == OFFSET_INIT && iter == 4'h0)
        else $error("search not initialised");
    AST_SEARCH_LEN: assert property (@(posedge i_clk) disable iff (i_rst)
        $fell(state == SLVQ_SEARCH) |-> $past(iter) == ITER_LAST && state == SLVQ_GAIN)
        else $error("search did not run ten iterations");
    AST_DONE: assert property (@(posedge i_clk) disable iff (i_rst)
        o_band_valid && o_band.band == BAND_LAST |=> o_frame_done ##1 !o_band_valid)
        else $error("frame end not signalled after last band");
endmodule
`default_nettype wire

// *** verification/slvq_src.sv ***
`timescale 1ns/1ns
`default_nettype none
module slvq_src
(
    input wire logic i_clk,
    input wire logic i_ready,
    input wire logic i_stall,
    input wire logic i_go,
    input wire logic [15:0] i_amp,
    input wire logic [7:0] i_words,
    output logic o_valid,
    output logic [15:0] o_data
);
    logic [7:0] sent;
    logic took;
    logic more;
    logic tick;

    initial
    begin
        o_valid = 1'b0;
        o_data = 16'h0000;
        sent = 8'h00;
        tick = 1'b0;
    end

    always @(posedge i_clk)
    begin
        took = o_valid && i_ready;
        if (i_go)
            sent = 8'h00;
        else if (took)
            sent = sent + 8'h01;
        more = sent < i_words;
        tick = ~tick;
        #1;
        // a word once offered stays put until it is taken
        if (took || !o_valid)
        begin
            o_valid = more && !(i_stall && tick);
            // idle data toggles so a stale word never looks valid
            o_data = o_valid ? (sent[0] ? -i_amp : i_amp) : ~o_data;
        end
    end
endmodule
`default_nettype wire

// *** verification/split_lattice_vector_quantizer_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
module split_lattice_vector_quantizer_tb
    import slvq_pkg::*;
;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_coef_valid;
    logic [15:0] i_coef;
    logic o_coef_ready;
    logic [15:0] i_bit_budget = 16'h0000;
    logic o_band_valid;
    slvq_band_s o_band;
    logic o_frame_done;
    logic [15:0] o_offset;
    logic stall = 1'b0;
    logic go = 1'b0;
    logic [15:0] amp = 16'h0000;
    logic [7:0] words = 8'h00;
    logic last_bv = 1'b0;
    logic full_seen = 1'b0;
    int err_count = 0;
    int compares = 0;
    int nband = 0;
    int ndone = 0;
    int taken = 0;
    int cbsum = 0;

    always #4 i_clk = ~i_clk;

    slvq_quantizer u_dut (.i_clk(i_clk), .i_rst(i_rst), .i_coef_valid(i_coef_valid),
        .i_coef(i_coef), .o_coef_ready(o_coef_ready), .i_bit_budget(i_bit_budget),
        .o_band_valid(o_band_valid), .o_band(o_band), .o_frame_done(o_frame_done),
        .o_offset(o_offset));

    slvq_src u_src (.i_clk(i_clk), .i_ready(o_coef_ready), .i_stall(stall), .i_go(go),
        .i_amp(amp), .i_words(words), .o_valid(i_coef_valid), .o_data(i_coef));

    task automatic results();
        $display("err_count %0d compares %0d", err_count, compares);
        if (err_count == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e)
        begin
            err_count++;
            $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
        end
    endtask

    task automatic check_band();
        slvq_band_s b;
        logic [15:0] s;
        logic [7:0] p;
        logic [31:0] n;
        logic [31:0] r;
        logic [31:0] t;
        int i;
        b = o_band;
        n = 32'(b.cb_num);
        r = n > 6 ? 2 : (n > 4 ? 1 : 0);
        t = 32'(b.trunc);
        s = 16'h0000;
        for (i = 0; i < 8; i++)
        begin
            s = s + b.point[i];
            p[i] = b.point[i][0];
            chk("base_point", $unsigned(16'($signed(b.point[i]) >>> r)), b.base_point[i]);
        end
        chk("band_order", nband % 8, b.band);
        chk("equal_parity", {8{p[0]}}, p);
        chk("sum_mod4", 0, s[1:0]);
        chk("cb_legal", 1, n <= 8 && n != 1);
        chk("ext_order", r, b.ext_order);
        chk("base_cb", n < 5 ? n : (n[0] ? 3 : 4), b.base_cb);
        chk("index_bits", n < 5 ? 4 * n : (n[0] ? 12 : 16) + 8 * r, b.index_bits);
        chk("trunc_band7", 0, t && b.band != 7);
        chk("unary_len", n == 0 ? 1 : n - t, b.unary_len);
        chk("unary", n == 0 ? 0 : ((1 << n) - 2) >> t, b.unary);
        chk("total_bits", n == 0 ? 1 : 5 * n - t, b.total_bits);
        chk("origin", 0, n == 0 && b.point != 0);
        chk("origin_qspec", 0, n == 0 && b.qspec != 0);
        nband++;
        cbsum += n;
    endtask

    always @(posedge i_clk)
    begin
        if (i_coef_valid && o_coef_ready)
            taken++;
        if (!i_rst && o_coef_ready === 1'b0)
            full_seen = 1'b1;
        if (o_band_valid)
            check_band();
        if (o_frame_done)
        begin
            chk("done_after_band7", 4'hF, {last_bv, o_band.band});
            ndone++;
        end
        last_bv = o_band_valid;
    end

    task automatic run(input logic [15:0] a, input logic [15:0] bud, input logic st,
                       input logic [7:0] nw, input int nf);
        int d0;
        int k;
        d0 = ndone;
        @(posedge i_clk);
        #1;
        amp = a;
        i_bit_budget = bud;
        stall = st;
        words = nw;
        go = 1'b1;
        @(posedge i_clk);
        #1;
        go = 1'b0;
        k = 0;
        while (ndone < d0 + nf && k < 5000)
        begin
            @(posedge i_clk);
            k++;
        end
        #1;
        chk("frames", d0 + nf, ndone);
    endtask

    task automatic t_reset();
        chk("ready_reset", 1, o_coef_ready);
        chk("pulses_reset", 0, {o_band_valid, o_frame_done});
        chk("offset_reset", 0, o_offset);
    endtask

    // silent frame: floor energy gives zero estimates, every step is undone
    task automatic t_zero();
        cbsum = 0;
        run(16'h0000, 16'h0064, 1'b0, 8'd64, 1);
        chk("cb_sum", 0, cbsum);
        chk("offset_zero", 0, o_offset);
    endtask

    // each band estimate 70 bits against a limit of 0.95 times 8 bits (1944/256): offset settles at 69
    task automatic t_loud();
        run(16'h0400, 16'h0010, 1'b1, 8'd64, 1);
        chk("offset_loud", 16'h4500, o_offset);
    endtask

    // three frames back to back fill the buffer while frames are processed
    task automatic t_fill();
        int t0;
        t0 = taken;
        full_seen = 1'b0;
        run(16'h0031, 16'h00F0, 1'b0, 8'd192, 3);
        chk("fifo_refused", 1, full_seen);
        chk("words_taken", t0 + 192, taken);
        chk("ready_empty", 1, o_coef_ready);
    endtask

    initial
    begin
        repeat (3) @(posedge i_clk);
        #1;
        i_rst = 1'b0;
        t_reset();
        t_zero();
        t_loud();
        t_fill();
        results();
    end

    initial
    begin
        #100000;
        err_count++;
        results();
    end
endmodule
`default_nettype wire
